// ### verilog/tbsc_params.svh
// Register offsets, field positions, reset values and coding constants
`ifndef TBSC_PARAMS_SVH
`define TBSC_PARAMS_SVH

// ************************************************
// Register indices (byte address is four times)
// ************************************************
`define TBSC_IDX_SH_NORM     8'h20
`define TBSC_IDX_SH_STBY     8'h21
`define TBSC_IDX_SH_SLEEP    8'h22
`define TBSC_IDX_SH_MODE     8'h23
`define TBSC_IDX_SH_CONF     8'h24
`define TBSC_IDX_TH_NORM     8'h2e
`define TBSC_IDX_TH_STBY     8'h2f
`define TBSC_IDX_TH_SLEEP    8'h30
`define TBSC_IDX_TH_MODE     8'h31
`define TBSC_IDX_TH_CONF     8'h32
`define TBSC_IDX_CTRL        8'h40
`define TBSC_IDX_STAT        8'h41

// ************************************************
// Reset values and write masks
// ************************************************
`define TBSC_RST_VOLT        8'h00
`define TBSC_RST_MODE        8'h08
`define TBSC_RST_CONF        8'h00
`define TBSC_MASK_VOLT       8'h3f
`define TBSC_MASK_MODE       8'h2f
`define TBSC_MASK_CONF       8'hff
`define TBSC_MASK_CTRL       8'h0f

// ************************************************
// Field positions
// ************************************************
`define TBSC_CONF_ILIM       0
`define TBSC_CONF_FREQ_LO    2
`define TBSC_CONF_PHASE_LO   4
`define TBSC_CONF_SPEED_LO   6
`define TBSC_CTRL_STATE_LO   0
`define TBSC_CTRL_GROUP_LO   2

// ************************************************
// Set-point coding, minimum and step in millivolts, plus low-warning code and half-cycle phase offset
// ************************************************
`define TBSC_VMIN_MV         16'd300
`define TBSC_VSTEP_MV        16'd25
`define TBSC_LIMIT_CODE      6'h0c
`define TBSC_HALF_CYCLE      2'h2

// ************************************************
// Timing counts
// ************************************************
`define TBSC_STRAP_SETTLE    2'h2

`endif

// ### verilog/tbsc_pkg.sv
// Types shared by the buck set-point control block
package tbsc_pkg;

   // Leg grouping codes
   typedef enum logic [1:0] {
      TBSC_GRP_ALL_SINGLE  = 2'h0,
      TBSC_GRP_SHARED_SNGL = 2'h1,
      TBSC_GRP_SHARED_DUAL = 2'h2,
      TBSC_GRP_RESERVED    = 2'h3
   } tbsc_group_e;

   // Operating states
   typedef enum logic [1:0] {
      TBSC_ST_NORMAL  = 2'h0,
      TBSC_ST_STANDBY = 2'h1,
      TBSC_ST_SLEEP   = 2'h2,
      TBSC_ST_RSVD    = 2'h3
   } tbsc_opstate_e;

   // Switching-node settings
   typedef struct packed {
      logic [1:0] speed;
      logic [1:0] phase;
      logic [1:0] freq;
   } tbsc_node_s;

   // One output's applied settings
   typedef struct packed {
      logic [5:0]  code;
      logic [15:0] millivolt;
      logic [7:0]  mode;
      logic        ilim;
      logic        lowWarn;
   } tbsc_out_s;

endpackage

// ### verilog/tbsc_sync2.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module tbsc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   // Data
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   logic [W-1:0] meta_q;

   // Two stages, first read only by second
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule

// ### verilog/tbsc_setpoint.sv
// Set-point selection and voltage coding for one output
`timescale 1ns/1ps
`include "tbsc_params.svh"
module tbsc_setpoint
   import tbsc_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   // Settings
   input  wire tbsc_opstate_e opState,
   input  wire logic [5:0]    normCode,
   input  wire logic [5:0]    stbyCode,
   input  wire logic [5:0]    sleepCode,
   input  wire logic [7:0]    modeReg,
   input  wire logic          ilim,
   // Applied result
   output tbsc_out_s          outSet
);

   logic [5:0] code;

   // Code chosen by operating state
   always_comb begin
      case (opState)
         TBSC_ST_STANDBY: code = stbyCode;
         TBSC_ST_SLEEP:   code = sleepCode;
         default:         code = normCode;
      endcase
   end

   // Registered voltage, linear from minimum
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         outSet <= '0;
      end else begin
         outSet.code      <= code;
         outSet.millivolt <= `TBSC_VMIN_MV + (16'(code) * `TBSC_VSTEP_MV);
         outSet.mode      <= modeReg;
         outSet.ilim      <= ilim;
         outSet.lowWarn   <= (code <= `TBSC_LIMIT_CODE);
      end
   end

endmodule

// ### verilog/tbsc_top.sv
// AXI4-Lite register bank and leg steering for the triple-leg buck group
`timescale 1ns/1ps
`include "tbsc_params.svh"

module tbsc_top
   import tbsc_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   // AXI4-Lite write address
   input  wire logic [31:0]   s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0]   s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Factory grouping strap and state pins
   input  wire logic [1:0]    legGroupingPin,
   input  wire logic [1:0]    opStatePin,
   // Switching-node settings
   output tbsc_node_s         legANode,
   output tbsc_node_s         legBNode,
   output tbsc_node_s         legCNode,
   // Applied output settings
   output tbsc_out_s          sharedOut,
   output tbsc_out_s          thirdOut,
   output tbsc_group_e        legGrouping
);

   // ************************************************
   // Register storage
   // ************************************************
   logic [7:0] regs_q [10];
   logic [3:0] ctrl_q;
   logic [1:0] strap;
   logic [1:0] pinState;
   logic       strapDone_q;
   logic [1:0] strapCnt_q;
   // Effective state, pin or software override
   tbsc_opstate_e opSel;

   // Map an index onto a storage slot, or -1
   function automatic int slotOf(input logic [7:0] idx);
      case (idx)
         `TBSC_IDX_SH_NORM:  slotOf = 0;
         `TBSC_IDX_SH_STBY:  slotOf = 1;
         `TBSC_IDX_SH_SLEEP: slotOf = 2;
         `TBSC_IDX_SH_MODE:  slotOf = 3;
         `TBSC_IDX_SH_CONF:  slotOf = 4;
         `TBSC_IDX_TH_NORM:  slotOf = 5;
         `TBSC_IDX_TH_STBY:  slotOf = 6;
         `TBSC_IDX_TH_SLEEP: slotOf = 7;
         `TBSC_IDX_TH_MODE:  slotOf = 8;
         `TBSC_IDX_TH_CONF:  slotOf = 9;
         default:            slotOf = -1;
      endcase
   endfunction

   // Writable bits per slot
   function automatic logic [7:0] maskOf(input int slot);
      case (slot)
         3, 8:    maskOf = `TBSC_MASK_MODE;
         4, 9:    maskOf = `TBSC_MASK_CONF;
         default: maskOf = `TBSC_MASK_VOLT;
      endcase
   endfunction

   // Reset value per slot
   function automatic logic [7:0] resetOf(input int slot);
      case (slot)
         3, 8:    resetOf = `TBSC_RST_MODE;
         4, 9:    resetOf = `TBSC_RST_CONF;
         default: resetOf = `TBSC_RST_VOLT;
      endcase
   endfunction

   // ************************************************
   // Pin synchronisers
   // ************************************************
   tbsc_sync2 #(.W(2)) u_syncStrap (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .asyncIn  (legGroupingPin),
      .syncOut  (strap)
   );

   tbsc_sync2 #(.W(2)) u_syncState (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .asyncIn  (opStatePin),
      .syncOut  (pinState)
   );

   // Grouping caught once, after the strap has crossed both sync stages
   // Capturing earlier would latch the synchroniser's reset zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         legGrouping <= TBSC_GRP_ALL_SINGLE;
         strapCnt_q  <= 2'h0;
         strapDone_q <= 1'b0;
      end else if (!strapDone_q) begin
         if (strapCnt_q == `TBSC_STRAP_SETTLE) begin
            legGrouping <= tbsc_group_e'(strap);
            strapDone_q <= 1'b1;
         end else begin
            strapCnt_q <= strapCnt_q + 2'h1;
         end
      end
   end

   // ************************************************
   // AXI4-Lite write path
   // ************************************************
   logic        awHeld_q;
   logic        wHeld_q;
   logic [7:0]  wIdx_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        doWrite;
   int          wSlot;

   assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign wSlot   = slotOf(wIdx_q);

   // Address capture, any order against data
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_q      <= 1'b0;
         wIdx_q        <= 8'h00;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q      <= 1'b1;
         wIdx_q        <= s_axi_awaddr[9:2];
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         awHeld_q      <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   // Data capture
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wHeld_q      <= 1'b0;
         wData_q      <= 32'h0000_0000;
         wStrb_q      <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q      <= 1'b1;
         wData_q      <= s_axi_wdata;
         wStrb_q      <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         wHeld_q      <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   // Write response, DECERR for unmapped
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wSlot >= 0 || wIdx_q == `TBSC_IDX_CTRL || wIdx_q == `TBSC_IDX_STAT) ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register storage, low byte lane only
   genvar g;
   generate
      for (g = 0; g < 10; g++) begin : gRegs
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               regs_q[g] <= resetOf(g);
            end else if (doWrite && wSlot == g && wStrb_q[0]) begin
               regs_q[g] <= wData_q[7:0] & maskOf(g);
            end
         end
      end
   endgenerate

   // Own control: state override and enable
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 4'h0;
      end else if (doWrite && wIdx_q == `TBSC_IDX_CTRL && wStrb_q[0]) begin
         ctrl_q <= 4'(wData_q[7:0] & `TBSC_MASK_CTRL);
      end
   end

   // ************************************************
   // AXI4-Lite read path
   // ************************************************
   logic [7:0] rdByte;
   logic       rdHit;
   int         rSlot;

   assign rSlot = slotOf(s_axi_araddr[9:2]);

   // Read data selection
   always_comb begin
      rdByte = 8'h00;
      rdHit  = 1'b1;
      if (rSlot >= 0) begin
         rdByte = regs_q[rSlot];
      end else if (s_axi_araddr[9:2] == `TBSC_IDX_CTRL) begin
         rdByte = {4'h0, ctrl_q};
      end else if (s_axi_araddr[9:2] == `TBSC_IDX_STAT) begin
         rdByte = {2'h0, thirdOut.lowWarn, sharedOut.lowWarn, opSel, legGrouping};
      end else begin
         rdHit = 1'b0;
      end
   end

   // Read answer one cycle after address
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
         s_axi_arready <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rdByte};
         s_axi_rresp   <= rdHit ? 2'h0 : 2'h3;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************
   // Operating state and set points
   // ************************************************

   // Software override when bit 2 set
   always_comb begin
      if (ctrl_q[2]) begin
         opSel = tbsc_opstate_e'(ctrl_q[1:0]);
      end else begin
         opSel = tbsc_opstate_e'(pinState);
      end
   end

   // Shared output set point, own registers
   tbsc_setpoint u_sharedSet (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .opState   (opSel),
      .normCode  (regs_q[0][5:0]),
      .stbyCode  (regs_q[1][5:0]),
      .sleepCode (regs_q[2][5:0]),
      .modeReg   (regs_q[3]),
      .ilim      (regs_q[4][`TBSC_CONF_ILIM]),
      .outSet    (sharedOut)
   );

   // Third output set point, own registers
   tbsc_setpoint u_thirdSet (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .opState   (opSel),
      .normCode  (regs_q[5][5:0]),
      .stbyCode  (regs_q[6][5:0]),
      .sleepCode (regs_q[7][5:0]),
      .modeReg   (regs_q[8]),
      .ilim      (regs_q[9][`TBSC_CONF_ILIM]),
      .outSet    (thirdOut)
   );

   // ************************************************
   // Switching-node steering
   // ************************************************
   tbsc_node_s sharedCfg;
   tbsc_node_s thirdCfg;

   // Field extraction, phase in quarter steps
   assign sharedCfg = '{speed: regs_q[4][7:6], phase: regs_q[4][5:4], freq: regs_q[4][3:2]};
   assign thirdCfg  = '{speed: regs_q[9][7:6], phase: regs_q[9][5:4], freq: regs_q[9][3:2]};

   // Per-grouping node settings
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         legANode <= '0;
         legBNode <= '0;
         legCNode <= '0;
      end else begin
         legCNode <= thirdCfg;
         case (legGrouping)
            TBSC_GRP_SHARED_SNGL: begin
               legANode <= sharedCfg;
               legBNode <= sharedCfg;
            end
            TBSC_GRP_SHARED_DUAL: begin
               legANode <= sharedCfg;
               legBNode <= '{speed: sharedCfg.speed, phase: sharedCfg.phase + `TBSC_HALF_CYCLE,
                             freq: sharedCfg.freq};
            end
            TBSC_GRP_ALL_SINGLE: begin
               legANode <= thirdCfg;
               legBNode <= thirdCfg;
            end
            default: begin
               legANode <= thirdCfg;
               legBNode <= thirdCfg;
            end
         endcase
      end
   end

endmodule

// ### tb/tbsc_top_monitor.sv
// Concurrent checks on the ports of the buck set-point control block
`timescale 1ns/1ps
module tbsc_top_monitor
   import tbsc_pkg::*;
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_b,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Leg and output settings
   input wire tbsc_node_s  legANode,
   input wire tbsc_node_s  legBNode,
   input wire tbsc_node_s  legCNode,
   input wire tbsc_out_s   sharedOut,
   input wire tbsc_out_s   thirdOut,
   input wire tbsc_group_e legGrouping
);
   logic [7:0] rdIdxQ;

   // Index of the read in flight
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) rdIdxQ <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) rdIdxQ <= s_axi_araddr[9:2];
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // ***************************
   // Set-point coding
   // ***************************
   property p_sh_mv;
      $past(rst_b) |-> sharedOut.millivolt == 16'h012c + 16'h0019 * sharedOut.code;
   endproperty
   a_sh_mv: assert property (p_sh_mv) else $error("shared millivolt not minimum plus steps");
   property p_th_mv;
      $past(rst_b) |-> thirdOut.millivolt == 16'h012c + 16'h0019 * thirdOut.code;
   endproperty
   a_th_mv: assert property (p_th_mv) else $error("third millivolt not minimum plus steps");

   // ***************************
   // Leg steering
   // ***************************
   property p_dual;
      legGrouping == TBSC_GRP_SHARED_DUAL && $past(legGrouping) == TBSC_GRP_SHARED_DUAL |->
         legBNode.phase == legANode.phase + 2'h2 && legBNode.freq == legANode.freq && legBNode.speed == legANode.speed;
   endproperty
   a_dual: assert property (p_dual) else $error("dual legs not half a cycle apart");
   property p_single_ab;
      legGrouping == TBSC_GRP_SHARED_SNGL && $past(legGrouping) == TBSC_GRP_SHARED_SNGL |-> legANode == legBNode;
   endproperty
   a_single_ab: assert property (p_single_ab) else $error("shared legs differ in single phase");
   property p_all_single;
      legGrouping == TBSC_GRP_ALL_SINGLE && $past(legGrouping) == TBSC_GRP_ALL_SINGLE |->
         legANode == legCNode && legBNode == legCNode;
   endproperty
   a_all_single: assert property (p_all_single) else $error("legs differ with all legs joined");

   // ***************************
   // Register bus
   // ***************************
   property p_rd_vz;
      s_axi_rvalid && rdIdxQ inside {8'h20, 8'h21, 8'h22, 8'h2e, 8'h2f, 8'h30} |-> s_axi_rdata[7:6] == 2'h0;
   endproperty
   a_rd_vz: assert property (p_rd_vz) else $error("unused voltage bits read nonzero");
   property p_bresp_due;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_bresp_due: assert property (p_bresp_due) else $error("write response late");
   property p_rdata_due;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rdata_due: assert property (p_rdata_due) else $error("read data late");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped before taken");
endmodule

bind tbsc_top tbsc_top_monitor u_tbsc_top_monitor (.*);

// ### tb/tbsc_top_bench.sv
// Self-checking bench for the buck set-point control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_fail++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tbsc_top_bench
   import tbsc_pkg::*;
;
   logic        core_clk, rst_b;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, legGroupingPin, opStatePin;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   tbsc_node_s  legANode, legBNode, legCNode;
   tbsc_out_s   sharedOut, thirdOut;
   tbsc_group_e legGrouping;
   int          n_fail = 0, compares = 0, mdl [256];
   int          regs [12] = '{'h20, 'h21, 'h22, 'h23, 'h24, 'h2e, 'h2f, 'h30, 'h31, 'h32, 'h25, 'h33};
   int          bnd [4] = '{'h0d, 'hcd, 'h3f, 'hff};

   tbsc_top u_tbsc_top (.*);

   // Clock
   always #2.5 core_clk = ~core_clk;

   // Write mask per register, zero where unmapped
   function automatic int msk(input int i);
      case (i)
         'h20, 'h21, 'h22, 'h2e, 'h2f, 'h30: return 'h3f;
         'h23, 'h31: return 'h2f;
         'h24, 'h32: return 'hff;
         'h40: return 'h0f;
         default: return 0;
      endcase
   endfunction

   // Reset with a given grouping strap, model back to reset values
   task automatic rstdo(input int g);
      legGroupingPin <= g[1:0];
      rst_b <= 1'b0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      foreach (mdl[i]) mdl[i] = (i == 'h23 || i == 'h31) ? 'h08 : 0;
   endtask

   // One write, address and data offered together
   task automatic axw(input int idx, input int d, input logic [3:0] st, output logic [1:0] r);
      s_axi_awaddr <= idx * 4;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (s_axi_awvalid !== 1'b0 || s_axi_wvalid !== 1'b0 || !s_axi_bvalid) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask

   // One read
   task automatic axr(input int idx, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= idx * 4;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!(s_axi_arvalid && s_axi_arready));
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask

   // Write and track the model
   task automatic wrc(input int idx, input int d, input logic [3:0] st);
      logic [1:0] r;
      axw(idx, d, st, r);
      `CHK("bresp", msk(idx) ? 0 : 3, r)
      if (st[0]) mdl[idx] = d & msk(idx);
   endtask

   // Read and compare with the model
   task automatic rdc(input int idx);
      logic [31:0] d;
      logic [1:0]  r;
      axr(idx, d, r);
      `CHK("rresp", (msk(idx) || idx == 'h41) ? 0 : 3, r)
      `CHK("rdata", mdl[idx], d)
   endtask

   // Switching-node settings for a grouping
   task automatic chkn(input int g);
      int na, nb, nc;
      nc = mdl['h32] >> 2;
      na = (g == 1 || g == 2) ? mdl['h24] >> 2 : nc;
      nb = (g == 2) ? (na & 'h33) | ((((na >> 2) + 2) & 3) << 2) : na;
      `CHK("legA", na, legANode)
      `CHK("legB", nb, legBNode)
      `CHK("legC", nc, legCNode)
   endtask

   // Applied settings for an operating state
   task automatic chko(input int st);
      int sc, tc;
      sc = mdl['h20 + st];
      tc = mdl['h2e + st];
      `CHK("shCode", sc, sharedOut.code)
      `CHK("thCode", tc, thirdOut.code)
      `CHK("shMv", 300 + 25 * sc, sharedOut.millivolt)
      `CHK("thMv", 300 + 25 * tc, thirdOut.millivolt)
      `CHK("shWarn", sc <= 12, sharedOut.lowWarn)
      `CHK("thWarn", tc <= 12, thirdOut.lowWarn)
      `CHK("shMode", mdl['h23], sharedOut.mode)
      `CHK("thIlim", mdl['h32] & 1, thirdOut.ilim)
   endtask

   // Verdict and end of run
   task automatic report_and_stop;
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Main sequence, one pass per grouping strap
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, legGroupingPin, opStatePin} = '0;
      void'($urandom(62));
      for (int g = 0; g < 4; g++) begin
         rstdo(g);
         `CHK("grouping", g, legGrouping)
         chko(0);
         if (g == 0) for (int i = 'h20; i < 'h34; i++) rdc(i);
         for (int k = 0; k < 36; k++) begin
            int d;
            d = $urandom;
            if (msk(regs[k % 12]) == 'h3f && (d & 'h3f) <= 12) d = d | 'h20;
            wrc(regs[k % 12], d, 4'($urandom));
         end
         wrc('h20, bnd[g], 4'h1);
         wrc('h2e, bnd[3 - g], 4'h1);
         for (int i = 'h20; i < 'h34; i++) rdc(i);
         repeat (2) @(posedge core_clk);
         chkn(g);
         for (int st = 0; st < 3; st++) begin
            opStatePin <= st[1:0];
            repeat (6) @(posedge core_clk);
            chko(st);
         end
         opStatePin <= 2'h0;
         // Software override to sleep while the pins say normal
         wrc('h40, 'h0e, 4'h1);
         repeat (3) @(posedge core_clk);
         chko(2);
         mdl['h41] = ((mdl['h30] <= 12) << 5) | ((mdl['h22] <= 12) << 4) | 'h08 | g;
         rdc('h40);
         rdc('h41);
         wrc('h40, 0, 4'h1);
      end
      report_and_stop;
   end

   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_fail++;
      report_and_stop;
   end
endmodule
